// ===== dv/pmc_ctl_master.sv
// Purpose: control master model issuing pixel control accesses
// Assumes: a strobe is set at a falling edge and taken at the next rising edge
// Notes:   released address and data show the inverse of the last value
`timescale 1ns/1ps
module pmc_ctl_master
  import pmc_pkg::*;
(
  input  wire logic                       clk_sys,
  output logic                            ctl_wr,
  output logic                            ctl_rd,
  output logic      [pmc_pkg::PMC_AW-1:0] ctl_addr,
  output logic      [pmc_pkg::PMC_DW-1:0] ctl_wdata,
  input  wire logic [pmc_pkg::PMC_DW-1:0] ctl_rdata,
  input  wire logic                       ctl_rvalid
);
  // idle bus at time zero
  initial begin
    ctl_wr    = 1'b0;
    ctl_rd    = 1'b0;
    ctl_addr  = 16'h0000;
    ctl_wdata = 16'h0000;
  end
  // pixel control address; the base code is fixed so no other register is hit
  function automatic logic [15:0] pa(input logic [4:0] rg, input logic bc, input logic tg, input logic [3:0] sl);
    return {rg, PMC_BASE_CODE, bc, 2'b00, tg, sl};
  endfunction
  // read address: exact region and a single slice bit, never broadcast
  function automatic logic [15:0] sa(input logic [4:0] rg, input int idx);
    return pa(rg, 1'b0, 1'b0, 4'h1 << idx);
  endfunction
  // one write, strobe held over exactly one rising edge
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    ctl_addr  = a;
    ctl_wdata = d;
    ctl_wr    = 1'b1;
    @(negedge clk_sys);
    ctl_wr    = 1'b0;
    ctl_addr  = ~a;
    ctl_wdata = ~d;
  endtask
  // one read; the answer is registered, so it stands in the following cycle
  task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic v);
    @(negedge clk_sys);
    ctl_addr = a;
    ctl_rd   = 1'b1;
    @(negedge clk_sys);
    ctl_rd   = 1'b0;
    ctl_addr = ~a;
    d        = ctl_rdata;
    v        = ctl_rvalid;
  endtask
  // latches power up unknown: write zero into both banks of every pixel
  task automatic init_latches;
    wr(pa(5'd0, 1'b1, 1'b0, 4'hF), 16'h0000);
    wr(PMC_CFG_ADDR, 16'h0000);
    wr(pa(5'd0, 1'b1, 1'b0, 4'h7), 16'hFFFF);
    wr(pa(5'd0, 1'b1, 1'b0, 4'h7), 16'h0000);
    wr(PMC_CFG_ADDR, 16'h0002);
    wr(pa(5'd0, 1'b1, 1'b0, 4'h7), 16'hFFFF);
    wr(pa(5'd0, 1'b1, 1'b0, 4'hF), 16'h0000);
    wr(PMC_CFG_ADDR, 16'h0000);
  endtask
endmodule

// ===== dv/tb_top.sv
// Purpose: self-checking bench for the pixel mask and pulse configuration block
// Assumes: master model drives the control port at falling edges
// Notes:   only the pixel at column 0 row 0 can show latch contents
`timescale 1ns/1ps
module tb_top;
  import pmc_pkg::*;
  logic                clk_sys, rst_n, ctl_wr, ctl_rd, ctl_rvalid, probe_hit, probe_out;
  logic                pixel_reset_command, test_pulse_analog, test_pulse_digital;
  logic                latch_data_bit, row_bank_select_bit, rv;
  logic [PMC_AW-1:0]   ctl_addr;
  logic [PMC_DW-1:0]   ctl_wdata, ctl_rdata, rd_d;
  logic [PMC_NCOL-1:0] column_select_line;
  logic [PMC_NROW-1:0] mask_row_select_line, pulse_row_select_line, analog_pulse_dcol, digital_pulse_dcol;
  int                  n_mismatch, tests_run, cyc;
  pmc_top pmc_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ctl_wr(ctl_wr), .ctl_rd(ctl_rd),
    .ctl_addr(ctl_addr), .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata), .ctl_rvalid(ctl_rvalid),
    .pixel_reset_command(pixel_reset_command), .test_pulse_analog(test_pulse_analog),
    .test_pulse_digital(test_pulse_digital), .probe_hit(probe_hit), .column_select_line(column_select_line),
    .mask_row_select_line(mask_row_select_line), .pulse_row_select_line(pulse_row_select_line),
    .latch_data_bit(latch_data_bit), .row_bank_select_bit(row_bank_select_bit),
    .analog_pulse_dcol(analog_pulse_dcol), .digital_pulse_dcol(digital_pulse_dcol), .probe_out(probe_out));
  pmc_ctl_master m (.clk_sys(clk_sys), .ctl_wr(ctl_wr), .ctl_rd(ctl_rd), .ctl_addr(ctl_addr),
    .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata), .ctl_rvalid(ctl_rvalid));
  // free-running 20 MHz clock
  always #25 clk_sys = ~clk_sys;
  // hang guard, well above the fewer than one hundred cycles the tests need
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // read with answer flag and data compared
  task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
    m.rd(a, rd_d, rv);
    chk({15'h0000, rv}, 16'h0001, "rvalid");
    chk(rd_d, exp, "rdata");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // reset state and first readback
  task automatic t_reset;
    chk({14'h0000, latch_data_bit, row_bank_select_bit}, 16'h0000, "cfg lines");
    chk({15'h0000, |{column_select_line, mask_row_select_line, pulse_row_select_line}}, 16'h0000, "grid");
    rchk(m.sa(5'd7, 2), PMC_SLICE_RST);
    $display("t_reset done");
  endtask
  // single-slice writes, line mapping and row bank demux
  task automatic t_slices;
    m.wr(m.pa(5'd5, 1'b0, 1'b0, 4'h1), 16'hA5C3);
    chk(column_select_line[175:160], 16'hA5C3, "col r5 lo");
    chk(column_select_line[191:176], 16'h0000, "col r5 hi");
    m.wr(m.pa(5'd31, 1'b0, 1'b0, 4'h2), 16'h8001);
    chk({15'h0000, column_select_line[1008]}, 16'h0001, "col 1008");
    chk(column_select_line[1023:1008], 16'h8001, "col r31 hi");
    rchk(m.sa(5'd5, 0), 16'hA5C3);
    rchk(m.sa(5'd31, 1), 16'h8001);
    // one write selecting both column slices of a single region
    m.wr(m.pa(5'd0, 1'b0, 1'b0, 4'h3), 16'h00F0);
    chk(column_select_line[15:0], 16'h00F0, "multi lo");
    chk(column_select_line[31:16], 16'h00F0, "multi hi");
    m.wr(m.pa(5'd0, 1'b1, 1'b0, 4'h3), 16'h0000);
    m.wr(m.pa(5'd2, 1'b0, 1'b0, 4'h4), 16'h0101);
    chk(mask_row_select_line[47:32], 16'h0101, "mask rows r2");
    rchk(m.sa(5'd2, 2), 16'h0101);
    chk({15'h0000, |pulse_row_select_line}, 16'h0000, "pulse rows idle");
    m.wr(PMC_CFG_ADDR, 16'h0002);
    chk(pulse_row_select_line[47:32], 16'h0101, "pulse rows r2");
    chk({15'h0000, |mask_row_select_line}, 16'h0000, "mask rows idle");
    m.wr(m.pa(5'd31, 1'b0, 1'b0, 4'h4), 16'h8000);
    chk(pulse_row_select_line[511:496], 16'h8000, "pulse rows r31");
    m.wr(PMC_CFG_ADDR, 16'h0000);
    m.wr(m.pa(5'd0, 1'b1, 1'b0, 4'h4), 16'h0000);
    $display("t_slices done");
  endtask
  // broadcast, toggle, gating, frozen config and refused accesses
  task automatic t_bcast;
    m.wr(m.pa(5'd9, 1'b1, 1'b0, 4'hF), 16'h1234);
    for (int r = 0; r < PMC_NREG; r++) begin
      chk(column_select_line[32*r+:16], 16'h1234, "bcast lo");
      chk(column_select_line[32*r+16+:16], 16'h1234, "bcast hi");
      chk(mask_row_select_line[16*r+:16], 16'h1234, "bcast row");
    end
    m.wr(m.pa(5'd0, 1'b1, 1'b1, 4'hF), 16'h0000);
    for (int r = 0; r < PMC_NREG; r++) begin
      chk(column_select_line[32*r+:16], 16'hEDCB, "toggle col");
      chk(mask_row_select_line[16*r+:16], 16'hEDCB, "toggle row");
    end
    rchk(m.sa(5'd30, 3), 16'h1234);
    // single-region toggle: write data must be ignored, neighbours untouched
    m.wr(m.pa(5'd3, 1'b0, 1'b1, 4'h4), 16'hFFFF);
    chk(mask_row_select_line[63:48], 16'h1234, "toggle r3 row");
    chk(mask_row_select_line[79:64], 16'hEDCB, "toggle r4 kept");
    m.wr(PMC_CFG_ADDR, 16'hFF03);
    chk({14'h0000, latch_data_bit, row_bank_select_bit}, 16'h0000, "cfg frozen");
    rchk(PMC_CFG_ADDR, 16'hFF00);
    test_pulse_analog = 1'b1;
    test_pulse_digital = 1'b1;
    @(negedge clk_sys);
    chk(analog_pulse_dcol[63:48], 16'h1234, "analog gate");
    chk(digital_pulse_dcol[63:48], 16'h1234, "digital gate");
    test_pulse_analog = 1'b0;
    @(negedge clk_sys);
    chk(analog_pulse_dcol[63:48], 16'h0000, "analog off");
    rchk(m.pa(5'd3, 1'b0, 1'b0, 4'h3), PMC_RD_NONE);
    m.wr({5'd3, 3'b011, 8'h01}, 16'hFFFF);
    chk(column_select_line[111:96], 16'hEDCB, "wrong base");
    m.wr(m.pa(5'd0, 1'b1, 1'b0, 4'hF), 16'h0000);
    test_pulse_digital = 1'b0;
    $display("t_bcast done");
  endtask
  // modelled pixel: mask load, hold, pixel reset immunity
  task automatic t_pixel;
    m.init_latches();
    probe_hit = 1'b1;
    m.wr(PMC_CFG_ADDR, 16'h0001);
    chk({15'h0000, latch_data_bit}, 16'h0001, "latch data");
    chk({15'h0000, probe_out}, 16'h0001, "unmasked hit");
    m.wr(m.pa(5'd0, 1'b0, 1'b0, 4'h1), 16'h0001);
    @(negedge clk_sys);
    chk({15'h0000, probe_out}, 16'h0001, "column only");
    m.wr(m.pa(5'd0, 1'b0, 1'b0, 4'h4), 16'h0001);
    @(negedge clk_sys);
    chk({15'h0000, probe_out}, 16'h0000, "masked");
    m.wr(m.pa(5'd0, 1'b0, 1'b0, 4'h4), 16'h0000);
    m.wr(PMC_CFG_ADDR, 16'h0000);
    pixel_reset_command = 1'b1;
    repeat (2) @(negedge clk_sys);
    pixel_reset_command = 1'b0;
    chk({15'h0000, probe_out}, 16'h0000, "held");
    m.wr(m.pa(5'd0, 1'b0, 1'b0, 4'h4), 16'h0001);
    @(negedge clk_sys);
    chk({15'h0000, probe_out}, 16'h0001, "unmasked again");
    rchk(16'h0600, PMC_RD_NONE);
    $display("t_pixel done");
  endtask
  // main sequence: inputs at time zero, 6-cycle reset, then the tests
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    {pixel_reset_command, test_pulse_analog, test_pulse_digital, probe_hit} = 4'h0;
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    t_reset();
    t_slices();
    t_bcast();
    t_pixel();
    report_and_stop();
  end
endmodule

// ===== src/pmc_pixel_cell.sv
// Purpose: one pixel's mask and pulse-enable latches and output gating
// Assumes: latches modelled by flops sampled while their enable is high
// Notes:   no reset on the latches; they power up unknown
`timescale 1ns/1ps
module pmc_pixel_cell (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic col_sel,
  input  wire logic mask_row_sel,
  input  wire logic pulse_row_sel,
  input  wire logic latch_data,
  input  wire logic pixel_reset_command,
  input  wire logic hit,
  input  wire logic digital_pulse,
  output logic      pixel_out,
  output logic      mask_en,
  output logic      pulse_en
);
  logic mask_r;
  logic pulse_r;
  logic mask_we;
  logic pulse_we;

  // enable needs column and row select together
  assign mask_we  = col_sel & mask_row_sel;  // RULE3
  assign pulse_we = col_sel & pulse_row_sel;  // RULE3

  // follow data while enabled, hold otherwise; pixel reset never touches them
  always_ff @(posedge clk_sys) begin  // RULE5
    if (mask_we) begin
      mask_r <= latch_data;  // RULE4
    end
    if (pulse_we) begin
      pulse_r <= latch_data;  // RULE4
    end
  end

  // a masked pixel looks unhit to the readout
  assign pixel_out = (hit | (digital_pulse & pulse_r)) & ~mask_r;  // RULE1
  assign mask_en   = mask_r;
  assign pulse_en  = pulse_r;

  mask_force_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE1
    mask_r |-> !pixel_out) else $error("masked pixel drives a hit");
  latch_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE4
    (!mask_we && !pulse_we) |=> ($stable(mask_r) && $stable(pulse_r)))
    else $error("latch changed while disabled");
  latch_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE3
    mask_we |=> (mask_r == $past(latch_data))) else $error("mask latch missed data");
  pixel_reset_command_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE5
    (pixel_reset_command && !mask_we && !pulse_we) |=> $stable(mask_r))
    else $error("pixel reset disturbed latch");
endmodule

// ===== src/pmc_pkg.sv
// Purpose: shared constants of the pixel mask and pulse configuration block
// Assumes: 16-bit control address and data; 32 regions of four 16-bit slices
// Notes:   field positions of the pixel control address live here; the master model's pa hard-codes the same layout
package pmc_pkg;
  localparam int          PMC_NREG      = 32;          // region modules
  localparam int          PMC_SLW       = 16;          // slice width
  localparam int          PMC_NCOL      = 1024;        // column select lines
  localparam int          PMC_NROW      = 512;         // row select lines per bank
  localparam int          PMC_AW        = 16;
  localparam int          PMC_DW        = 16;
  // pixel control address fields
  localparam int          PMC_REG_HI    = 15;
  localparam int          PMC_REG_LO    = 11;
  localparam int          PMC_BASE_HI   = 10;
  localparam int          PMC_BASE_LO   = 8;
  localparam logic [2:0]  PMC_BASE_CODE = 3'h4;        // 3'b100
  localparam int          PMC_BCAST_BIT = 7;
  localparam int          PMC_TOG_BIT   = 4;
  localparam int          PMC_SEL_PG    = 3;           // pulse gating slice
  localparam int          PMC_SEL_ROW   = 2;           // row select slice
  localparam int          PMC_SEL_CHI   = 1;           // upper column slice
  localparam int          PMC_SEL_CLO   = 0;           // lower column slice
  // pixel latch configuration register
  localparam logic [15:0] PMC_CFG_ADDR  = 16'h0500;
  localparam int          PMC_CFG_DATA  = 0;           // latch data bit
  localparam int          PMC_CFG_BANK  = 1;           // row bank select bit
  localparam logic [15:0] PMC_CFG_RST   = 16'h0000;
  localparam logic [15:0] PMC_SLICE_RST = 16'h0000;
  localparam logic [15:0] PMC_RD_NONE   = 16'h0000;    // answer to unmapped reads
  // location of the modelled pixel cell
  localparam int          PMC_PROBE_COL = 0;
  localparam int          PMC_PROBE_ROW = 0;
endpackage

// ===== src/pmc_top.sv
// Purpose: periphery registers driving the pixel select grid and pulse gating
// Assumes: control port is a single-cycle read/write strobe pair; reads answer next cycle
// Notes:   only one pixel cell is modelled, at the probe location
// Contract
// [RULE1] masked pixel output forced low
// [RULE2] pixel latches cannot be read back
// [RULE3] latch enabled by column and row together
// [RULE4] enabled latch follows data, else holds
// [RULE5] pixel reset leaves latches; software initialises
// [RULE6] 1024 columns, 512 mask rows, 512 pulse rows
// [RULE7] 32 regions, four 16-bit slices each
// [RULE8] region n drives columns 32n..32n+31
// [RULE9] bit 0 drives leftmost column of group
// [RULE10] region n drives rows 16n..16n+15
// [RULE11] bank bit routes rows to mask or pulse
// [RULE12] unselected bank rows held low
// [RULE13] global latch data from config register
// [RULE14] pulse gating per double column
// [RULE15] slice registers readable and writable
// [RULE16] split address with base code 3'b100
// [RULE17] broadcast writes all regions at once
// [RULE18] toggle inverts column and row slices only
// [RULE19] low address bits select slices independently
// [RULE20] reads need exact region and one-hot select
// [RULE21] latch data held while a pair selected
// [RULE22] multi-slice writes update together
`timescale 1ns/1ps
module pmc_top
  import pmc_pkg::*;
(
  input  wire logic                         clk_sys,
  input  wire logic                         rst_n,
  input  wire logic                         ctl_wr,
  input  wire logic                         ctl_rd,
  input  wire logic [pmc_pkg::PMC_AW-1:0]   ctl_addr,
  input  wire logic [pmc_pkg::PMC_DW-1:0]   ctl_wdata,
  output logic      [pmc_pkg::PMC_DW-1:0]   ctl_rdata,
  output logic                              ctl_rvalid,
  input  wire logic                         pixel_reset_command,
  input  wire logic                         test_pulse_analog,
  input  wire logic                         test_pulse_digital,
  input  wire logic                         probe_hit,
  output logic      [pmc_pkg::PMC_NCOL-1:0] column_select_line,
  output logic      [pmc_pkg::PMC_NROW-1:0] mask_row_select_line,
  output logic      [pmc_pkg::PMC_NROW-1:0] pulse_row_select_line,
  output logic                              latch_data_bit,
  output logic                              row_bank_select_bit,
  output logic      [pmc_pkg::PMC_NROW-1:0] analog_pulse_dcol,
  output logic      [pmc_pkg::PMC_NROW-1:0] digital_pulse_dcol,
  output logic                              probe_out
);
  import pmc_pkg::*;

  logic [PMC_SLW-1:0] col_lo_r [PMC_NREG];
  logic [PMC_SLW-1:0] col_hi_r [PMC_NREG];
  logic [PMC_SLW-1:0] row_r    [PMC_NREG];
  logic [PMC_SLW-1:0] pgate_r  [PMC_NREG];
  logic [PMC_DW-1:0]  cfg_r;
  logic [PMC_DW-1:0]  rdata_nxt;
  logic [PMC_NROW-1:0] row_lines;
  logic [4:0]         reg_idx;
  logic [3:0]         sel;
  logic               pix_acc;
  logic               bcast;
  logic               tog;
  logic               cfg_acc;
  logic               pair_active;

  // write value of a column or row slice: toggle wins over data
  function automatic logic [15:0] slice_nxt(input logic [15:0] cur, input logic [15:0] wd,
                                            input logic t);
    slice_nxt = t ? ~cur : wd;
  endfunction

  // true when exactly one slice is selected
  function automatic logic onehot4(input logic [3:0] s);
    onehot4 = (s != 4'h0) && ((s & (s - 4'h1)) == 4'h0);
  endfunction

  // address decode of the split pixel control address
  assign pix_acc = (ctl_addr[PMC_BASE_HI:PMC_BASE_LO] == PMC_BASE_CODE);  // RULE16
  assign reg_idx = ctl_addr[PMC_REG_HI:PMC_REG_LO];  // RULE16
  assign bcast   = ctl_addr[PMC_BCAST_BIT];
  assign tog     = ctl_addr[PMC_TOG_BIT];
  assign sel     = ctl_addr[PMC_SEL_PG:PMC_SEL_CLO];  // RULE19
  assign cfg_acc = (ctl_addr == PMC_CFG_ADDR);

  // slice registers; every selected slice of every hit region loads in one cycle, except gating slices on a toggled write
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int r = 0; r < PMC_NREG; r++) begin
        col_lo_r[r] <= PMC_SLICE_RST;
        col_hi_r[r] <= PMC_SLICE_RST;
        row_r[r]    <= PMC_SLICE_RST;
        pgate_r[r]  <= PMC_SLICE_RST;
      end
    end else if (ctl_wr && pix_acc) begin
      for (int r = 0; r < PMC_NREG; r++) begin
        if (bcast || (reg_idx == 5'(r))) begin  // RULE17
          if (sel[PMC_SEL_CLO]) begin
            col_lo_r[r] <= slice_nxt(col_lo_r[r], ctl_wdata, tog);  // RULE18 RULE22
          end
          if (sel[PMC_SEL_CHI]) begin
            col_hi_r[r] <= slice_nxt(col_hi_r[r], ctl_wdata, tog);  // RULE18 RULE22
          end
          if (sel[PMC_SEL_ROW]) begin
            row_r[r] <= slice_nxt(row_r[r], ctl_wdata, tog);  // RULE18 RULE22
          end
          // gating slices have no toggle; a toggled write leaves them alone
          if (sel[PMC_SEL_PG] && !tog) begin
            pgate_r[r] <= ctl_wdata;  // RULE18
          end
        end
      end
    end
  end

  // any latch currently enabled somewhere in the matrix
  assign pair_active = (|column_select_line) && (|row_lines);

  // config register; data and bank bits freeze while a latch pair is open,
  // so a stray write cannot corrupt latches that are being written
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_r <= PMC_CFG_RST;
    end else if (ctl_wr && cfg_acc) begin
      cfg_r <= ctl_wdata;
      if (pair_active) begin
        cfg_r[PMC_CFG_DATA] <= cfg_r[PMC_CFG_DATA];  // RULE21
        cfg_r[PMC_CFG_BANK] <= cfg_r[PMC_CFG_BANK];  // RULE21
      end
    end
  end

  // read mux; in-pixel latches have no read path, only the periphery slices and the config register
  always_comb begin
    rdata_nxt = PMC_RD_NONE;
    if (cfg_acc) begin
      rdata_nxt = cfg_r;
    end else if (pix_acc && onehot4(sel)) begin  // RULE20
      unique case (1'b1)
        sel[PMC_SEL_CLO]: rdata_nxt = col_lo_r[reg_idx];  // RULE15
        sel[PMC_SEL_CHI]: rdata_nxt = col_hi_r[reg_idx];  // RULE15
        sel[PMC_SEL_ROW]: rdata_nxt = row_r[reg_idx];  // RULE15
        sel[PMC_SEL_PG]:  rdata_nxt = pgate_r[reg_idx];  // RULE15 RULE2
      endcase
    end
  end

  // read answer one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctl_rdata  <= PMC_RD_NONE;
      ctl_rvalid <= 1'b0;
    end else begin
      ctl_rvalid <= ctl_rd;
      if (ctl_rd) begin
        ctl_rdata <= rdata_nxt;
      end
    end
  end

  // grid mapping: region n owns columns 32n.. and rows 16n.., bit 0 leftmost/topmost
  always_comb begin
    for (int r = 0; r < PMC_NREG; r++) begin
      column_select_line[32*r +: PMC_SLW]      = col_lo_r[r];  // RULE8 RULE9 RULE6
      column_select_line[32*r + 16 +: PMC_SLW] = col_hi_r[r];  // RULE8 RULE7
      row_lines[16*r +: PMC_SLW]               = row_r[r];  // RULE10
      analog_pulse_dcol[16*r +: PMC_SLW]       = pgate_r[r] & {PMC_SLW{test_pulse_analog}};  // RULE14
      digital_pulse_dcol[16*r +: PMC_SLW]      = pgate_r[r] & {PMC_SLW{test_pulse_digital}};  // RULE14
    end
  end

  // demultiplexer: the bank not chosen is held low
  assign mask_row_select_line  = row_bank_select_bit ? '0 : row_lines;  // RULE11 RULE12
  assign pulse_row_select_line = row_bank_select_bit ? row_lines : '0;  // RULE11 RULE12
  assign latch_data_bit        = cfg_r[PMC_CFG_DATA];  // RULE13
  assign row_bank_select_bit   = cfg_r[PMC_CFG_BANK];

  // one modelled pixel at the probe location
  pmc_pixel_cell u_probe (
    .clk_sys             (clk_sys),
    .rst_n               (rst_n),
    .col_sel             (column_select_line[PMC_PROBE_COL]),
    .mask_row_sel        (mask_row_select_line[PMC_PROBE_ROW]),
    .pulse_row_sel       (pulse_row_select_line[PMC_PROBE_ROW]),
    .latch_data          (latch_data_bit),
    .pixel_reset_command (pixel_reset_command),
    .hit                 (probe_hit),
    .digital_pulse       (digital_pulse_dcol[PMC_PROBE_COL/2]),
    .pixel_out           (probe_out),
    .mask_en             (),
    .pulse_en            ()
  );

  // checks
  bank_excl_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE12
    !((|mask_row_select_line) && (|pulse_row_select_line))) else $error("both row banks active");
  mask_route_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE11
    !row_bank_select_bit |-> (mask_row_select_line == row_lines && pulse_row_select_line == '0))
    else $error("mask bank misrouted");
  data_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE13
    (ctl_wr && cfg_acc && !pair_active) |=> (latch_data_bit == $past(ctl_wdata[PMC_CFG_DATA])))
    else $error("latch data not loaded");
  bcast_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE17
    (ctl_wr && pix_acc && bcast && !tog && sel[PMC_SEL_CLO])
    |=> (col_lo_r[0] == $past(ctl_wdata) && col_lo_r[31] == $past(ctl_wdata)))
    else $error("broadcast missed a region");
  toggle_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE18
    (ctl_wr && pix_acc && tog && sel[PMC_SEL_ROW] && !bcast && reg_idx == 5'h03)
    |=> (row_r[3] == ~$past(row_r[3]))) else $error("toggle did not invert");
  pgate_tog_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE18
    (ctl_wr && pix_acc && tog) |=> $stable(pgate_r[0])) else $error("gating slice toggled");
  multi_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE22
    (ctl_wr && pix_acc && !tog && !bcast && reg_idx == 5'h00 && sel[PMC_SEL_CLO] && sel[PMC_SEL_CHI])
    |=> (col_lo_r[0] == $past(ctl_wdata) && col_hi_r[0] == $past(ctl_wdata)))
    else $error("multi-slice write split");
  read_ans_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE15
    (ctl_rd && pix_acc && sel == 4'h4 && reg_idx == 5'h02) |=> (ctl_rvalid && ctl_rdata == $past(row_r[2])))
    else $error("slice read wrong");
  data_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE21
    pair_active |=> $stable(latch_data_bit) || !$past(ctl_wr)) else $error("latch data moved under select");
  col_map_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RULE8
    column_select_line[1023:1008] == col_hi_r[31]) else $error("column map broken");

  bcast_c: cover property (@(posedge clk_sys) disable iff (!rst_n) ctl_wr && pix_acc && bcast && sel == 4'hF);
  toggle_c: cover property (@(posedge clk_sys) disable iff (!rst_n) ctl_wr && pix_acc && tog);
  pulse_bank_c: cover property (@(posedge clk_sys) disable iff (!rst_n) |pulse_row_select_line);
  read_c: cover property (@(posedge clk_sys) disable iff (!rst_n) ctl_rd && pix_acc && onehot4(sel));
endmodule
